// >>> hw/acc_alu.sv
// Eight-bit arithmetic and logic unit with its six-bit condition flag register.
// Assumes the decoder presents operands and one operation strobe per instruction,
// and that it routes the result to the accumulator or memory as the opcode says.
`timescale 1ns/1ns
`include "acc_alu_map.svh"

module acc_alu
   import acc_alu_pkg::*;
(
   input wire logic SYS_CLK, // System clock, 10 MHz.
   input wire logic RESET, // Asynchronous reset, active high.
   input wire logic OP_STROBE, // One-cycle pulse: execute OP_CODE now.
   input wire acc_op_t OP_CODE, // Operation to execute.
   input wire logic [7:0] OPERAND_A, // Accumulator operand.
   input wire logic [7:0] OPERAND_M, // Memory or second accumulator operand.
   input wire logic STACKED_MASK, // Interrupt mask bit pulled on return.
   output logic [7:0] RESULT, // Registered result of the last operation.
   output logic RESULT_WRITE, // Pulse: write RESULT back to the destination.
   output logic [5:0] CONDITION_FLAGS // Current condition_flags register.
);

   // ------------------------------------------------------------
   // Combinational operation core
   // ------------------------------------------------------------
   logic [7:0] res;
   logic write_back;
   logic [5:0] flags_d;
   logic [5:0] flags_q;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] add_b;
   logic add_cin;
   logic is_sub;
   logic [3:0] lo_nib;
   logic [3:0] hi_nib;
   logic lo_fix;
   logic hi_fix;
   logic [8:0] daa_sum;
   logic add_ovf;
   logic sub_ovf;
   logic nz_update;
   logic res_zero;
   wire [8:0] zero_chain;
   logic half_q;
   logic mask_q;
   logic neg_q;
   logic zero_q;
   logic ovf_q;
   logic carry_q;

   // Reset image of the flag register, split into bits by the flag flops.
   localparam logic [5:0] flags_rst = `ACC_FLAGS_RESET;

   // One shared adder serves add, subtract and compare, and negate has its own; subtraction is an
   // inverted operand plus one, which keeps add and subtract on a single carry chain.
   always_comb begin
      is_sub = (OP_CODE == ACC_OP_SUB) || (OP_CODE == ACC_OP_SBC) ||
               (OP_CODE == ACC_OP_CMP) || (OP_CODE == ACC_OP_NEGATE);
      add_b = is_sub ? ~OPERAND_M : OPERAND_M;
      case (OP_CODE)
         ACC_OP_SBC: add_cin = ~flags_q[`ACC_FLAG_C];
         ACC_OP_ADC: add_cin = flags_q[`ACC_FLAG_C];
         ACC_OP_SUB, ACC_OP_CMP, ACC_OP_NEGATE: add_cin = 1'b1;
         default: add_cin = 1'b0;
      endcase
   end

   assign sum = (OP_CODE == ACC_OP_NEGATE) ? ({1'b0, ~OPERAND_M} + 9'h001) :
                ({1'b0, OPERAND_A} + {1'b0, add_b} + {8'h00, add_cin});
   assign low_sum = {1'b0, OPERAND_A[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};

   // Signed overflow terms. An add overflows when both operands share a sign
   // that the sum lacks; a subtract when the signs differ and the difference
   // takes the sign of the subtrahend. The plain operand is used rather than
   // the inverted one, so the borrow-in cannot disturb the sign test.
   // overflow terms
   assign add_ovf = (OPERAND_A[7] == OPERAND_M[7]) && (sum[7] != OPERAND_A[7]);
   assign sub_ovf = (OPERAND_A[7] != OPERAND_M[7]) && (sum[7] != OPERAND_A[7]);

   // Decimal adjust correction terms.
   assign lo_nib = OPERAND_A[3:0];
   assign hi_nib = OPERAND_A[7:4];
   assign lo_fix = (lo_nib > `ACC_BCD_MAX) || flags_q[`ACC_FLAG_H];
   assign hi_fix = (hi_nib > `ACC_BCD_MAX) || flags_q[`ACC_FLAG_C] ||
                   ((lo_nib > `ACC_BCD_MAX) && (hi_nib == `ACC_BCD_MAX));
   assign daa_sum = {1'b0, OPERAND_A} +
                    {1'b0, (hi_fix ? `ACC_BCD_FIX : 4'h0), (lo_fix ? `ACC_BCD_FIX : 4'h0)};

   // ------------------------------------------------------------
   // Flag helper terms
   // ------------------------------------------------------------

   // zero detect
   // The zero test is a ripple of OR terms, one per result bit. Eight levels
   // are nothing at this clock rate, and every bit gets the same small cell.
   assign zero_chain[0] = 1'b0;
   for (genvar b = 0; b < 8; b++) begin : g_zero
      assign zero_chain[b + 1] = zero_chain[b] | res[b];
   end
   assign res_zero = ~zero_chain[8];

   // N and Z follow every arithmetic, logic and test result. The flag set
   // and clear operations, the interrupt ones and both flag transfers leave
   // them alone, except that a load from A sets them with the other flags.
   // Unknown codes fall to the default and change nothing.
   always_comb begin
      case (OP_CODE)
         ACC_OP_ADD, ACC_OP_ADC, ACC_OP_SUB, ACC_OP_SBC, ACC_OP_CMP: begin
            nz_update = 1'b1;
         end
         ACC_OP_NEGATE, ACC_OP_INVERT, ACC_OP_DECADJ: begin
            nz_update = 1'b1;
         end
         ACC_OP_AND, ACC_OP_OR, ACC_OP_XOR, ACC_OP_BIT, ACC_OP_ZTEST: begin
            nz_update = 1'b1;
         end
         default: begin
            nz_update = 1'b0;
         end
      endcase
   end

   // Result and next flag value; every unlisted flag holds its value.
   always_comb begin
      res = 8'h00;
      write_back = 1'b0;
      flags_d = flags_q;
      case (OP_CODE)
         ACC_OP_ADD, ACC_OP_ADC: begin
            res = sum[7:0];
            write_back = 1'b1;
            flags_d[`ACC_FLAG_H] = low_sum[4];
            flags_d[`ACC_FLAG_V] = add_ovf;
            flags_d[`ACC_FLAG_C] = sum[8];
         end
         ACC_OP_SUB, ACC_OP_SBC, ACC_OP_CMP: begin
            res = sum[7:0];
            write_back = (OP_CODE != ACC_OP_CMP);
            flags_d[`ACC_FLAG_V] = sub_ovf;
            flags_d[`ACC_FLAG_C] = ~sum[8];
         end
         ACC_OP_NEGATE: begin
            res = sum[7:0];
            write_back = 1'b1;
            flags_d[`ACC_FLAG_V] = (sum[7:0] == `ACC_NEG_MIN);
            flags_d[`ACC_FLAG_C] = (sum[7:0] != 8'h00);
         end
         ACC_OP_INVERT: begin
            res = ~OPERAND_M;
            write_back = 1'b1;
            flags_d[`ACC_FLAG_V] = 1'b0;
            flags_d[`ACC_FLAG_C] = 1'b1;
         end
         ACC_OP_AND, ACC_OP_OR, ACC_OP_XOR, ACC_OP_BIT: begin
            case (OP_CODE)
               ACC_OP_OR: res = OPERAND_A | OPERAND_M;
               ACC_OP_XOR: res = OPERAND_A ^ OPERAND_M;
               default: res = OPERAND_A & OPERAND_M;
            endcase
            write_back = (OP_CODE != ACC_OP_BIT);
            flags_d[`ACC_FLAG_V] = 1'b0;
         end
         ACC_OP_ZTEST: begin
            res = OPERAND_M;
            flags_d[`ACC_FLAG_V] = 1'b0;
            flags_d[`ACC_FLAG_C] = 1'b0;
         end
         ACC_OP_DECADJ: begin
            res = daa_sum[7:0];
            write_back = 1'b1;
            flags_d[`ACC_FLAG_C] = flags_q[`ACC_FLAG_C] || hi_fix || daa_sum[8];
         end
         ACC_OP_CLC: flags_d[`ACC_FLAG_C] = 1'b0;
         ACC_OP_SEC: flags_d[`ACC_FLAG_C] = 1'b1;
         ACC_OP_CLV: flags_d[`ACC_FLAG_V] = 1'b0;
         ACC_OP_SEV: flags_d[`ACC_FLAG_V] = 1'b1;
         ACC_OP_MASK, ACC_OP_IRQ: flags_d[`ACC_FLAG_I] = 1'b1;
         ACC_OP_UNMASK: flags_d[`ACC_FLAG_I] = 1'b0;
         ACC_OP_IRET: begin
            if (!STACKED_MASK) begin
               flags_d[`ACC_FLAG_I] = 1'b0;
            end
         end
         ACC_OP_TAP: flags_d = OPERAND_A[5:0];
         ACC_OP_FLAGS_RD: begin
            res = {2'b11, flags_q};
            write_back = 1'b1;
         end
         default: begin
            res = 8'h00;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------

   // Each flag has its own register so that its update condition reads at
   // a glance. All of them load only on a strobed execute edge: the next
   // instruction then sees the flags of the previous one, and idle cycles,
   // in which the decoder may present anything on the operand lines, leave
   // the flags exactly as they were.

   // half-carry register
   // Only the add operations and a flag load put a new value into flags_d; the rest hold it.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         half_q <= flags_rst[`ACC_FLAG_H];
      end else if (OP_STROBE) begin
         half_q <= flags_d[`ACC_FLAG_H];
      end
   end

   // interrupt mask register
   // The mask comes out of reset set, so no interrupt is taken before
   // software has had the chance to prepare for one.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         mask_q <= flags_rst[`ACC_FLAG_I];
      end else if (OP_STROBE) begin
         mask_q <= flags_d[`ACC_FLAG_I];
      end
   end

   // negative from bit 7
   // Arithmetic, logic and test operations copy bit 7; a flag load takes it from A.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         neg_q <= flags_rst[`ACC_FLAG_N];
      end else if (OP_STROBE) begin
         neg_q <= nz_update ? res[7] : flags_d[`ACC_FLAG_N];
      end
   end

   // zero flag register
   // Uses the ripple detect above, which sees the same result as bit 7 does.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         zero_q <= flags_rst[`ACC_FLAG_Z];
      end else if (OP_STROBE) begin
         zero_q <= nz_update ? res_zero : flags_d[`ACC_FLAG_Z];
      end
   end

   // overflow register
   // Logic, invert and zero-test operations force it low through flags_d; compare sets it as a subtract does.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         ovf_q <= flags_rst[`ACC_FLAG_V];
      end else if (OP_STROBE) begin
         ovf_q <= flags_d[`ACC_FLAG_V];
      end
   end

   // carry register
   // Subtractions store the borrow here, which is what the next
   // subtract-with-borrow and the decimal adjust read back.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         carry_q <= flags_rst[`ACC_FLAG_C];
      end else if (OP_STROBE) begin
         carry_q <= flags_d[`ACC_FLAG_C];
      end
   end

   // flag bit order
   // Packed view in register order, H at bit 5 down to C at bit 0.
   assign flags_q = {half_q, mask_q, neg_q, zero_q, ovf_q, carry_q};

   // Result register. It loads on every strobe, written back or not, so a
   // test operation still leaves its value visible for debug.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         RESULT <= 8'h00;
      end else if (OP_STROBE) begin
         RESULT <= res;
      end
   end

   // Write-back pulse, one cycle long after each strobe whose operation
   // changes its destination.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         RESULT_WRITE <= 1'b0;
      end else begin
         RESULT_WRITE <= OP_STROBE && write_back;
      end
   end

   assign CONDITION_FLAGS = flags_q;

endmodule

// >>> hw/acc_alu_map.svh
// Field positions, reset value and correction constants of the flag unit.
// Assumes inclusion by bare name from the datapath module.
`ifndef ACC_ALU_MAP_SVH
`define ACC_ALU_MAP_SVH

// Bit positions inside the condition_flags register.
`define ACC_FLAG_H 5
`define ACC_FLAG_I 4
`define ACC_FLAG_N 3
`define ACC_FLAG_Z 2
`define ACC_FLAG_V 1
`define ACC_FLAG_C 0

// Flag register value after reset (the interrupt mask starts set).
`define ACC_FLAGS_RESET 6'h10

// Decimal correction constants and the negate overflow value.
`define ACC_BCD_FIX 4'h6
`define ACC_BCD_MAX 4'h9
`define ACC_NEG_MIN 8'h80

`endif

// >>> hw/acc_alu_pkg.sv
// Types shared by the arithmetic unit and its users.
// Assumes the decoder drives one operation code per executed instruction.
package acc_alu_pkg;

   // Operation codes presented by the decoder with a one-cycle strobe.
   typedef enum logic [4:0] {
      ACC_OP_NONE,
      ACC_OP_ADD,
      ACC_OP_ADC,
      ACC_OP_SUB,
      ACC_OP_SBC,
      ACC_OP_CMP,
      ACC_OP_NEGATE,
      ACC_OP_INVERT,
      ACC_OP_AND,
      ACC_OP_OR,
      ACC_OP_XOR,
      ACC_OP_BIT,
      ACC_OP_ZTEST,
      ACC_OP_DECADJ,
      ACC_OP_CLC,
      ACC_OP_SEC,
      ACC_OP_CLV,
      ACC_OP_SEV,
      ACC_OP_MASK,
      ACC_OP_UNMASK,
      ACC_OP_TAP,
      ACC_OP_FLAGS_RD,
      ACC_OP_IRET,
      ACC_OP_IRQ
   } acc_op_t;

endpackage

// >>> dv/acc_alu_sva.sv
// Concurrent checks on the ports of the arithmetic unit.
// Assumes one strobed operation per edge and is bound to acc_alu below.
`timescale 1ns/1ns
module acc_alu_chk
   import acc_alu_pkg::*;
(
   input wire logic SYS_CLK, // Clock.
   input wire logic RESET, // Reset, active high.
   input wire logic OP_STROBE, // Strobe.
   input wire acc_op_t OP_CODE, // Operation.
   input wire logic [7:0] OPERAND_A, // Operand A.
   input wire logic [7:0] OPERAND_M, // Operand M.
   input wire logic STACKED_MASK, // Stacked mask.
   input wire logic [7:0] RESULT, // Result.
   input wire logic RESULT_WRITE, // Write pulse.
   input wire logic [5:0] CONDITION_FLAGS // Flags.
);
   // ----------
   // Capture
   // ----------
   logic stb_q;
   logic sm_q;
   acc_op_t op_q;
   logic [7:0] a_q;
   logic [7:0] m_q;
   logic [5:0] f_q;
   wire [5:0] fl = CONDITION_FLAGS;
   // The old flags are kept so that chained operations can be judged.
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         stb_q <= 1'b0;
      end else begin
         stb_q <= OP_STROBE;
         {sm_q, a_q, m_q, f_q} <= {STACKED_MASK, OPERAND_A, OPERAND_M, fl};
         op_q <= OP_CODE;
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   a_add_sum: assert property (stb_q && op_q == ACC_OP_ADD |->
      {fl[0], RESULT} == {1'b0, a_q} + {1'b0, m_q} && fl[1] == (a_q[7] == m_q[7]
      && RESULT[7] != a_q[7]) && fl[5] == ({1'b0, a_q[3:0]} + m_q[3:0] > 5'h0f))
      else $error("add result or flags wrong");
   a_nz_track: assert property (stb_q && op_q inside {ACC_OP_ADD, ACC_OP_ADC,
      ACC_OP_SUB, ACC_OP_SBC, ACC_OP_NEGATE, ACC_OP_INVERT, ACC_OP_AND, ACC_OP_OR, ACC_OP_XOR,
      ACC_OP_DECADJ} |-> fl[3] == RESULT[7] && fl[2] == (RESULT == 8'h00))
      else $error("N or Z does not follow result");
   a_logic_flags: assert property (stb_q && op_q inside {ACC_OP_AND, ACC_OP_OR,
      ACC_OP_XOR, ACC_OP_BIT} |-> !fl[1] && fl[0] == f_q[0] && fl[5] == f_q[5])
      else $error("logic op flags wrong");
   a_neg_result: assert property (stb_q && op_q == ACC_OP_NEGATE |->
      RESULT == 8'h00 - m_q && fl[1] == (RESULT == 8'h80)) else $error("negate wrong");
   a_com_flags: assert property (stb_q && op_q == ACC_OP_INVERT |->
      RESULT == ~m_q && !fl[1] && fl[0]) else $error("invert wrong");
   a_sbc_diff: assert property (stb_q && op_q == ACC_OP_SBC |->
      RESULT == a_q - m_q - f_q[0] && RESULT_WRITE) else $error("borrow subtract wrong");
   a_tap_load: assert property (stb_q && op_q == ACC_OP_TAP |->
      fl == a_q[5:0]) else $error("flag load wrong");
   a_test_nowrite: assert property (stb_q && op_q inside {ACC_OP_BIT, ACC_OP_ZTEST,
      ACC_OP_CMP} |-> !RESULT_WRITE) else $error("test op wrote back");
   a_mask_ops: assert property (stb_q && op_q inside {ACC_OP_MASK, ACC_OP_IRQ,
      ACC_OP_UNMASK, ACC_OP_IRET} |-> fl[4] == (op_q inside {ACC_OP_MASK, ACC_OP_IRQ}
      || op_q == ACC_OP_IRET && sm_q && f_q[4])) else $error("interrupt mask wrong");
   a_idle_hold: assert property (!stb_q |-> $stable(fl) && !RESULT_WRITE)
      else $error("flags moved without a strobe");
   a_bcd_carry: assert property (stb_q && op_q == ACC_OP_DECADJ && f_q[0] |-> fl[0])
      else $error("decimal adjust cleared carry");
endmodule

bind acc_alu acc_alu_chk u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .OP_STROBE(OP_STROBE),
   .OP_CODE(OP_CODE), .OPERAND_A(OPERAND_A), .OPERAND_M(OPERAND_M),
   .STACKED_MASK(STACKED_MASK), .RESULT(RESULT), .RESULT_WRITE(RESULT_WRITE),
   .CONDITION_FLAGS(CONDITION_FLAGS));

// >>> dv/acc_dec_model.sv
// Model of the instruction decoder that feeds the arithmetic unit.
// Assumes the bench asks for one operation per cycle with go.
`timescale 1ns/1ns
module acc_dec_model
   import acc_alu_pkg::*;
(
   input wire logic clk, // Processor clock.
   input wire logic go, // Issue the request.
   input wire acc_op_t op, // Requested operation.
   input wire logic [7:0] a, // Accumulator value.
   input wire logic [7:0] m, // Memory value.
   input wire logic sm, // Stacked mask bit.
   output logic stb, // Strobe to the unit.
   output acc_op_t op_o, // Operation to the unit.
   output logic [7:0] a_o, // Operand A.
   output logic [7:0] m_o, // Operand M.
   output logic sm_o // Stacked mask.
);
   // ----------
   // Drive
   // ----------
   logic [7:0] junk_q = 8'h5a;
   // Idle operands churn, so a unit that samples without a strobe is caught.
   always_ff @(posedge clk) begin
      junk_q <= junk_q + 8'h35;
   end
   assign stb = go;
   assign op_o = go ? op : acc_op_t'(junk_q[4:0]);
   assign a_o = go ? a : junk_q;
   assign m_o = go ? m : ~junk_q;
   assign sm_o = go ? sm : junk_q[0];
endmodule

// >>> dv/acc_alu_tb.sv
// Self-checking bench for the arithmetic unit and its flags.
// Assumes the decoder model and the bound checker.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb
   import acc_alu_pkg::*;
;
   typedef struct packed {
      acc_op_t op;
      logic [7:0] a;
      logic [7:0] m;
      logic [7:0] res;
      logic sm;
      logic wr;
      logic [5:0] flg;
   } acc_row_t;
   localparam int NR = 33;
   // ----------
   // Cases: op, A, M, result, then {mask, write, flags}; flags chain.
   // ----------
   acc_row_t rows [NR] = '{{ACC_OP_ADD, 32'h7f01807a}, {ACC_OP_ADD, 32'h19284170},
      {ACC_OP_DECADJ, 32'h41004770}, {ACC_OP_ADD, 32'h99019a58},
      {ACC_OP_DECADJ, 32'h9a000055}, {ACC_OP_SBC, 32'h10010e50},
      {ACC_OP_NEGATE, 32'h0080805b}, {ACC_OP_NEGATE, 32'h00000054},
      {ACC_OP_INVERT, 32'h00ff0055}, {ACC_OP_AND, 32'hf08f8059}, {ACC_OP_OR, 32'h00000055},
      {ACC_OP_XOR, 32'hff0ff059}, {ACC_OP_BIT, 32'h0ff00015}, {ACC_OP_ZTEST, 32'h00800018},
      {ACC_OP_CMP, 32'h01020019}, {ACC_OP_SUB, 32'h80017f52}, {ACC_OP_SEC, 32'h00000013},
      {ACC_OP_CLC, 32'h00000012}, {ACC_OP_CLV, 32'h00000010}, {ACC_OP_SEV, 32'h00000012},
      {ACC_OP_UNMASK, 32'h00000002}, {ACC_OP_MASK, 32'h00000012}, {ACC_OP_TAP, 32'h3f00003f},
      {ACC_OP_FLAGS_RD, 32'h0000ff7f}, {ACC_OP_TAP, 32'h01000001},
      {ACC_OP_ADC, 32'h0f001060}, {ACC_OP_NONE, 32'h00000020}, {ACC_OP_IRQ, 32'h00000030},
      {ACC_OP_IRET, 32'h00000020}, {ACC_OP_IRQ, 32'h00000030}, {ACC_OP_IRET, 32'h000000b0},
      {ACC_OP_DECADJ, 32'ha0000671}, {ACC_OP_DECADJ, 32'h12007871}};
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic go = 1'b0;
   logic sm = 1'b0;
   acc_op_t op = ACC_OP_NONE;
   logic [7:0] a = 8'h00;
   logic [7:0] m = 8'h00;
   logic stb, osm, wr;
   acc_op_t opc;
   logic [7:0] oa, om, result;
   logic [5:0] flags;
   int err_total = 0;
   int n_tests = 0;
   always #50 sys_clk = ~sys_clk;
   acc_dec_model u_dec (.clk(sys_clk), .go(go), .op(op), .a(a), .m(m), .sm(sm), .stb(stb),
      .op_o(opc), .a_o(oa), .m_o(om), .sm_o(osm));
   acc_alu u_dut (.SYS_CLK(sys_clk), .RESET(reset), .OP_STROBE(stb), .OP_CODE(opc),
      .OPERAND_A(oa), .OPERAND_M(om), .STACKED_MASK(osm), .RESULT(result),
      .RESULT_WRITE(wr), .CONDITION_FLAGS(flags));
   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Rows go back to back; each row's answer is checked as the next is issued.
   initial begin
      repeat (3) @(posedge sys_clk);
      #10 reset = 1'b0;
      for (int i = 0; i <= NR; i++) begin
         @(posedge sys_clk);
         #10;
         if (i > 0) begin
            `CHK("flags", rows[i-1].flg, flags)
            `CHK("write", rows[i-1].wr, wr)
            if (rows[i-1].wr || rows[i-1].op == ACC_OP_NONE) `CHK("result", rows[i-1].res, result)
            $display("row %0d done", i - 1);
         end
         go = (i < NR);
         op = rows[i % NR].op;
         {a, m, sm} = {rows[i % NR].a, rows[i % NR].m, rows[i % NR].sm};
      end
      // Idle cycles leave the flags alone.
      repeat (3) @(posedge sys_clk);
      #10;
      `CHK("idle flags", 6'h31, flags)
      $display("idle test done");
      // Reset in mid-run, then an add on the first edge after release.
      reset = 1'b1;
      #1;
      `CHK("reset flags", 6'h10, flags)
      repeat (3) @(posedge sys_clk);
      #10 reset = 1'b0;
      go = 1'b1;
      op = ACC_OP_ADD;
      {a, m} = {8'hff, 8'h01};
      @(posedge sys_clk);
      #10 go = 1'b0;
      `CHK("wrap flags", 6'h35, flags)
      `CHK("wrap result", 8'h00, result)
      $display("reset test done");
      complete_run();
   end
   // Watchdog far beyond the few dozen cycles the tests need.
   initial begin
      #1000000;
      err_total++;
      complete_run();
   end
endmodule
